// ==== rtl/yard_map.svh ====
// register offsets, field positions, reset values and timing counts of the yard sequencer
`ifndef YARD_MAP_SVH
`define YARD_MAP_SVH

`define YARD_MAX_SIDINGS 32
`define YARD_MAX_UNITS   15

`define YARD_CLK_HZ      100000000
`define YARD_SEC_S       1
`define YARD_PULSE_MS    100
`define YARD_DB_MS       1

`define YARD_DEP_MIN     5'h02
`define YARD_DEP_MAX     5'h14
`define YARD_DEP_RST     5'h05

`define YARD_ADR_CTRL    8'h00
`define YARD_ADR_DEPART  8'h04
`define YARD_ADR_STATUS  8'h08
`define YARD_ADR_OCC     8'h0c
`define YARD_ADR_REL     8'h10

`define YARD_CTRL_MODE_LO  0
`define YARD_CTRL_MODE_HI  1
`define YARD_CTRL_ENTRY    2
`define YARD_CTRL_RESTART  3

`define YARD_LFSR_RST    8'h01

`endif

// ==== rtl/yard_pkg.sv ====
// types shared by the yard sequencer and its input filter
package yard_pkg;

  typedef enum logic [1:0] {MODE_MANUAL, MODE_RANDOM, MODE_FIFO} mode_t;

  typedef enum logic [2:0] {ST_INIT, ST_SCAN, ST_RUN, ST_VFREEZE, ST_HALT} state_t;

  typedef enum logic [1:0] {FLT_NONE, FLT_VOLTAGE, FLT_CAR_LEFT, FLT_UNIT_LOST} fault_t;

  typedef struct packed {
    logic [31:0] occ;
    logic [31:0] exit_btn;
    logic [14:0] unit;
    logic        strap;
    logic        inhibit_n;
    logic        volt_ok;
    logic [2:0]  mode_btn;
  } pins_t;

  localparam int PINS_W = $bits(pins_t);

  typedef struct packed {
    logic [PINS_W-1:0] sync1;
    logic [PINS_W-1:0] sync2;
    logic [PINS_W-1:0] s0;
    logic [PINS_W-1:0] s1;
    logic [PINS_W-1:0] out;
    logic [31:0]       tick;
    logic [1:0]        primed;
    logic              ready;
  } filt_t;

  typedef struct packed {
    state_t           st;
    mode_t            mode;
    logic             booted;
    logic             entry_en;
    logic [4:0]       dep_s;
    fault_t           fault;
    logic [5:0]       n;
    logic [14:0]      units;
    logic [31:0]      occ;
    logic [31:0]      body;
    logic [31:0]      stop;
    logic [31:0][5:0] rank;
    logic [5:0]       nocc;
    logic             rel_act;
    logic [4:0]       rel_idx;
    logic             pend;
    logic [31:0]      pend_excl;
    logic [31:0]      prev_btn;
    logic [31:0]      presc;
    logic [4:0]       dep_left;
    logic [31:0]      tb_pend;
    logic [31:0]      tt_pend;
    logic [31:0]      tb_out;
    logic [31:0]      tt_out;
    logic [31:0]      pcnt;
    logic             pact;
    logic [7:0]       lfsr;
    logic [31:0]      red;
    logic [31:0]      green;
    logic             entry_pwr;
    logic [2:0]       mode_led;
    logic [15:0]      fault_led;
    logic             nv_we;
    logic [31:0]      rdata;
  } seq_t;

endpackage

// ==== rtl/input_filter.sv ====
// two-flop synchroniser and three-sample debounce for all yard pins
`timescale 1ns/1ps
module input_filter
  import yard_pkg::*;
#(
  parameter int unsigned DB_CYCLES = 100000
) (
  input  wire logic  i_clock,  // system clock
  input  wire logic  i_rst,    // synchronous reset
  input  wire pins_t i_pins,   // raw pins
  output pins_t      o_pins,   // filtered pins
  output logic       o_ready   // samples settled
);

  filt_t             q;
  filt_t             d;
  logic [PINS_W-1:0] eq;

  always_comb begin
    d = q;
    eq = '0;
    d.sync1 = i_pins;
    d.sync2 = q.sync1;
    if (q.tick == DB_CYCLES - 1) begin
      d.tick = '0;
      d.s0 = q.sync2;
      d.s1 = q.s0;
      // a bit moves only after three equal samples
      eq = ~(q.sync2 ^ q.s0) & ~(q.s0 ^ q.s1);
      d.out = (q.out & ~eq) | (q.sync2 & eq);
      if (q.primed != 2'h3) begin
        d.primed = q.primed + 2'h1;
      end else begin
        d.ready = 1'b1;
      end
    end else begin
      d.tick = q.tick + 32'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_pins  = pins_t'(q.out);
  assign o_ready = q.ready;

endmodule

// ==== rtl/staging_yard_sequencer.sv ====
// staging yard sequencer: siding power, turnout pulses, departure release, fault freeze
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "yard_map.svh"
module staging_yard_sequencer
  import yard_pkg::*;
#(
  parameter int unsigned SEC_CYCLES   = `YARD_SEC_S * `YARD_CLK_HZ,
  parameter int unsigned PULSE_CYCLES = `YARD_PULSE_MS * (`YARD_CLK_HZ / 1000),
  parameter int unsigned DB_CYCLES    = `YARD_DB_MS * (`YARD_CLK_HZ / 1000)
) (
  input  wire logic        i_clock,         // 100 mhz clock
  input  wire logic        i_rst,           // synchronous reset, high
  input  wire logic [31:0] i_occ,           // stop section occupied
  input  wire logic [31:0] i_exit_btn,      // on-board exit buttons
  input  wire logic [31:0] i_exit_btn_ext,  // panel exit buttons
  input  wire logic [14:0] i_unit_present,  // expansion unit attached
  input  wire logic        i_single_strap,  // last unit has one siding
  input  wire logic        i_inhibit_n,     // low blocks departures
  input  wire logic        i_track_volt_ok, // track voltage present
  input  wire logic [2:0]  i_mode_btn,      // manual, random, fifo
  input  wire logic [1:0]  i_mode_nv,       // stored mode
  input  wire logic [7:0]  i_addr,          // register address
  input  wire logic [31:0] i_wdata,         // write data
  input  wire logic        i_wr,            // write strobe
  input  wire logic        i_rd,            // read strobe
  output logic      [31:0] o_rdata,         // read data, next cycle
  output logic      [31:0] o_stop_pwr,      // section a power
  output logic      [31:0] o_body_pwr,      // section b power
  output logic      [31:0] o_turn_branch,   // branch coil pulse
  output logic      [31:0] o_turn_through,  // through coil pulse
  output logic      [31:0] o_led_red,       // occupied
  output logic      [31:0] o_led_green,     // free
  output logic             o_entry_pwr,     // entrance stop section
  output logic      [1:0]  o_fault,         // fault code
  output logic      [15:0] o_fault_led,     // per module fault led
  output logic      [2:0]  o_mode_led,      // one-hot mode
  output logic             o_mode_nv_we,    // store mode pulse
  output logic      [1:0]  o_mode_nv        // mode to store
);

  pins_t       raw;
  pins_t       p;
  logic        rdy;
  seq_t        q;
  seq_t        d;
  logic [31:0] vmask;
  logic [31:0] nmask;
  logic [31:0] arr;
  logic [31:0] bp;
  logic [31:0] cand;
  logic [31:0] tb_new;
  logic [31:0] tt_new;
  logic [4:0]  tgt;
  logic [4:0]  idx;
  logic        found;
  logic        allow;
  logic        chain;
  logic [3:0]  cnt;
  logic [5:0]  nsid;
  logic [5:0]  acc;

  always_comb begin
    raw.occ       = i_occ;
    raw.exit_btn  = i_exit_btn | i_exit_btn_ext;
    raw.unit      = i_unit_present;
    raw.strap     = i_single_strap;
    raw.inhibit_n = i_inhibit_n;
    raw.volt_ok   = i_track_volt_ok;
    raw.mode_btn  = i_mode_btn;
  end

  input_filter #(
    .DB_CYCLES (DB_CYCLES)
  ) u_filter (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_pins  (raw),
    .o_pins  (p),
    .o_ready (rdy)
  );

  always_comb begin
    d = q;
    vmask = '0;
    nmask = '0;
    arr = '0;
    bp = '0;
    cand = '0;
    tb_new = '0;
    tt_new = '0;
    tgt = '0;
    idx = '0;
    found = 1'b0;
    allow = 1'b0;
    chain = 1'b1;
    cnt = '0;
    nsid = '0;
    acc = '0;
    d.rdata = '0;
    d.nv_we = 1'b0;
    d.lfsr = {q.lfsr[6:0], q.lfsr[7] ^ q.lfsr[5] ^ q.lfsr[4] ^ q.lfsr[3]};
    d.prev_btn = p.exit_btn;
    for (int i = 0; i < 32; i++) vmask[i] = (6'(i) < q.n);

    case (q.st)
      ST_INIT: begin
        d.occ = '0;
        d.body = '0;
        d.stop = '0;
        d.rel_act = 1'b0;
        d.pend = 1'b0;
        d.presc = '0;
        d.fault = FLT_NONE;
        if (rdy) begin
          if (!q.booted) begin
            d.booted = 1'b1;
            // unprogrammed storage falls back to manual
            d.mode = (i_mode_nv == 2'h3) ? MODE_MANUAL : mode_t'(i_mode_nv);
          end
          d.st = ST_SCAN;
        end
      end
      ST_SCAN: begin
        // units count only while the chain is unbroken
        d.units = '0;
        for (int k = 0; k < `YARD_MAX_UNITS; k++) begin
          if (chain && p.unit[k]) begin
            cnt = cnt + 4'h1;
            d.units[k] = 1'b1;
          end else begin
            chain = 1'b0;
          end
        end
        nsid = 6'h02 + {1'b0, cnt, 1'b0} - {5'h00, (cnt != 4'h0) && p.strap};
        d.n = nsid;
        for (int i = 0; i < 32; i++) nmask[i] = (6'(i) < nsid);
        d.occ = p.occ & nmask;
        d.body = ~d.occ & nmask;
        d.stop = '0;
        d.tb_pend = ~d.occ & nmask;
        d.tt_pend = d.occ;
        // true arrival order is lost across power-down; index order stands in
        for (int i = 0; i < 32; i++) begin
          d.rank[i] = acc;
          if (d.occ[i]) acc = acc + 6'h01;
        end
        d.nocc = acc;
        d.st = ST_RUN;
      end
      ST_RUN: begin
        if (!p.volt_ok) begin
          d.st = ST_VFREEZE;
          d.fault = FLT_VOLTAGE;
        end else if ((q.units & ~p.unit) != 15'h0000) begin
          d.st = ST_HALT;
          d.fault = FLT_UNIT_LOST;
        end else begin
          arr = p.occ & ~q.occ & vmask;
          bp = p.exit_btn & ~q.prev_btn & q.occ & vmask;
          if (q.rel_act) begin
            bp[q.rel_idx] = 1'b0;
          end
          allow = p.inhibit_n && !q.rel_act;
          cand = q.occ & vmask & ~q.pend_excl;
          if (allow && (bp != 32'h0)) begin
            for (int i = 31; i >= 0; i--) begin
              if (bp[i]) begin
                tgt = 5'(i);
                found = 1'b1;
              end
            end
          end else if (allow && q.pend) begin
            if (q.mode == MODE_FIFO) begin
              for (int i = 0; i < 32; i++) begin
                if (!found && cand[i] && (q.rank[i] == 6'h00)) begin
                  tgt = 5'(i);
                  found = 1'b1;
                end
              end
            end else begin
              for (int k = 0; k < 32; k++) begin
                idx = q.lfsr[4:0] + 5'(k);
                if (!found && cand[idx]) begin
                  tgt = idx;
                  found = 1'b1;
                end
              end
            end
            // nothing to send away: the arrival is spent
            d.pend = 1'b0;
          end
          if (found) begin
            d.body[tgt] = 1'b1;
            d.stop[tgt] = 1'b1;
            d.rel_act = 1'b1;
            d.rel_idx = tgt;
            d.dep_left = q.dep_s;
            d.presc = '0;
            d.pend = 1'b0;
            for (int j = 0; j < 32; j++) begin
              if (q.occ[j] && (q.rank[j] > q.rank[tgt])) begin
                d.rank[j] = q.rank[j] - 6'h01;
              end
            end
            d.nocc = q.nocc - 6'h01;
          end
          if (arr != 32'h0) begin
            acc = d.nocc;
            for (int i = 0; i < 32; i++) begin
              if (arr[i]) begin
                d.occ[i] = 1'b1;
                d.body[i] = 1'b0;
                tt_new[i] = 1'b1;
                d.rank[i] = acc;
                acc = acc + 6'h01;
              end
            end
            d.nocc = acc;
            if (q.mode != MODE_MANUAL) begin
              // simultaneous arrivals share one release
              d.pend = 1'b1;
              d.pend_excl = arr;
            end
          end
          if (q.rel_act) begin
            if (q.presc == SEC_CYCLES - 1) begin
              d.presc = '0;
              d.dep_left = q.dep_left - 5'h01;
              if (q.dep_left == 5'h01) begin
                d.rel_act = 1'b0;
                if (p.occ[q.rel_idx]) begin
                  d.st = ST_HALT;
                  d.fault = FLT_CAR_LEFT;
                end else begin
                  d.occ[q.rel_idx] = 1'b0;
                  d.stop[q.rel_idx] = 1'b0;
                  tb_new[q.rel_idx] = 1'b1;
                end
              end
            end else begin
              d.presc = q.presc + 32'h1;
            end
          end
        end
      end
      ST_VFREEZE: begin
        // siding power held and release timer paused; the turnout pulse slot keeps running
        if (p.volt_ok) begin
          d.st = ST_RUN;
          d.fault = FLT_NONE;
        end
      end
      ST_HALT: begin
        d.st = ST_HALT;
      end
      default: begin
        d.st = ST_INIT;
      end
    endcase

    // one shared pulse slot; later requests wait for the coil to rest
    if (q.pact) begin
      if (q.pcnt == PULSE_CYCLES - 1) begin
        d.pact = 1'b0;
        d.tb_out = '0;
        d.tt_out = '0;
      end else begin
        d.pcnt = q.pcnt + 32'h1;
      end
    end else if ((q.tb_pend | q.tt_pend) != 32'h0) begin
      d.pact = 1'b1;
      d.pcnt = '0;
      d.tb_out = q.tb_pend;
      d.tt_out = q.tt_pend;
      d.tb_pend = '0;
      d.tt_pend = '0;
    end
    if (q.st == ST_RUN) begin
      d.tb_pend = (d.tb_pend & ~tt_new) | tb_new;
      d.tt_pend = (d.tt_pend & ~tb_new) | tt_new;
    end

    for (int k = 0; k < 3; k++) begin
      if (p.mode_btn[k] && rdy && q.booted && (q.mode != mode_t'(k))) begin
        d.mode = mode_t'(k);
        d.nv_we = 1'b1;
      end
    end

    if (i_wr) begin
      case (i_addr)
        `YARD_ADR_CTRL: begin
          if (i_wdata[`YARD_CTRL_MODE_HI:`YARD_CTRL_MODE_LO] != 2'h3) begin
            d.mode = mode_t'(i_wdata[`YARD_CTRL_MODE_HI:`YARD_CTRL_MODE_LO]);
            d.nv_we = 1'b1;
          end
          d.entry_en = i_wdata[`YARD_CTRL_ENTRY];
          if (i_wdata[`YARD_CTRL_RESTART]) begin
            d.st = ST_INIT;
          end
        end
        `YARD_ADR_DEPART: begin
          // out-of-range times are ignored, the old value stays
          if ((i_wdata[31:5] == 27'h0) && (i_wdata[4:0] >= `YARD_DEP_MIN)
              && (i_wdata[4:0] <= `YARD_DEP_MAX)) begin
            d.dep_s = i_wdata[4:0];
          end
        end
        default: begin
          d.dep_s = d.dep_s;
        end
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        `YARD_ADR_CTRL:   d.rdata = {28'h0, 1'b0, q.entry_en, q.mode};
        `YARD_ADR_DEPART: d.rdata = {27'h0, q.dep_s};
        `YARD_ADR_STATUS: d.rdata = {16'h0, q.units[9:0], q.n} | {27'h0, q.fault, q.st} << 16;
        `YARD_ADR_OCC:    d.rdata = q.occ & vmask;
        `YARD_ADR_REL:    d.rdata = {20'h0, q.dep_left, q.rel_act, 1'b0, q.rel_idx};
        default:          d.rdata = '0;
      endcase
    end

    d.red = q.occ & vmask;
    d.green = ~q.occ & vmask;
    d.entry_pwr = !(q.entry_en && (q.st != ST_INIT) && ((q.occ & vmask) == vmask));
    d.mode_led = 3'h1 << q.mode;
    if (q.fault == FLT_NONE) begin
      d.fault_led = '0;
    end else if (q.fault == FLT_UNIT_LOST) begin
      d.fault_led = {q.units & ~p.unit, 1'b0};
    end else begin
      d.fault_led = {q.units, 1'b1};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      q <= '0;
      q.dep_s <= `YARD_DEP_RST;
      q.lfsr <= `YARD_LFSR_RST;
    end else begin
      q <= d;
    end
  end

  assign o_rdata        = q.rdata;
  assign o_stop_pwr     = q.stop;
  assign o_body_pwr     = q.body;
  assign o_turn_branch  = q.tb_out;
  assign o_turn_through = q.tt_out;
  assign o_led_red      = q.red;
  assign o_led_green    = q.green;
  assign o_entry_pwr    = q.entry_pwr;
  assign o_fault        = q.fault;
  assign o_fault_led    = q.fault_led;
  assign o_mode_led     = q.mode_led;
  assign o_mode_nv_we   = q.nv_we;
  assign o_mode_nv      = q.mode;

endmodule

// ==== sim/yard_seq_assertions.sv ====
// port-level checks of the yard sequencer, bound into its top module
`timescale 1ns/1ps
module yard_seq_checker #(
  parameter int unsigned SEC_CYCLES   = 20,
  parameter int unsigned PULSE_CYCLES = 5,
  parameter int unsigned DB_CYCLES    = 2
) (
  input wire logic        i_clock,        // clock
  input wire logic        i_rst,          // reset
  input wire logic        i_inhibit_n,    // departure block
  input wire logic        i_rd,           // read strobe
  input wire logic [31:0] o_rdata,        // read data
  input wire logic [31:0] o_stop_pwr,     // section a power
  input wire logic [31:0] o_body_pwr,     // section b power
  input wire logic [31:0] o_turn_branch,  // branch pulse
  input wire logic [31:0] o_turn_through, // through pulse
  input wire logic [31:0] o_led_red,      // occupied
  input wire logic [31:0] o_led_green,    // free
  input wire logic [1:0]  o_fault         // fault code
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  localparam int unsigned MIN_GAP = 2 * SEC_CYCLES - 1;
  logic [63:0] pv;
  logic [63:0] prev_q;
  logic [31:0] pcnt_q;
  logic [31:0] gap_q;
  logic [31:0] stop_q;
  logic        rel;
  assign pv  = {o_turn_branch, o_turn_through};
  assign rel = |(o_stop_pwr & ~stop_q);
  // pulse slots are grouped, so length is counted per distinct coil pattern
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prev_q <= '0;
      pcnt_q <= '0;
      gap_q  <= '1;
      stop_q <= '0;
    end else begin
      prev_q <= pv;
      stop_q <= o_stop_pwr;
      pcnt_q <= (pv == 64'h0) ? 32'h0 : (pv != prev_q) ? 32'h1 : pcnt_q + 32'h1;
      gap_q  <= rel ? 32'h0 : (gap_q != '1) ? gap_q + 32'h1 : gap_q;
    end
  end
  sequence inhibit_held;
    (!i_inhibit_n) [*8] ##1 (!i_inhibit_n) [*4];
  endsequence
  sequence fault_held;
    o_fault != 2'h0 ##1 o_fault == $past(o_fault);
  endsequence
  read_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its slot");
  coil_excl_a: assert property ((o_turn_branch & o_turn_through) == 32'h0)
    else $error("both coils pulsed");
  pulse_max_a: assert property (pv != 0 && pv == prev_q |-> pcnt_q < PULSE_CYCLES)
    else $error("turnout pulse too long");
  pulse_len_a: assert property (prev_q != 0 && pv != prev_q |-> pcnt_q == PULSE_CYCLES)
    else $error("turnout pulse too short");
  inhibit_block_a: assert property (inhibit_held |-> !rel)
    else $error("release while inhibited");
  one_release_a: assert property ($onehot0(o_stop_pwr & ~stop_q))
    else $error("several releases at once");
  release_both_a: assert property (rel |-> (o_stop_pwr & ~stop_q & ~o_body_pwr) == 0)
    else $error("release without body power");
  release_gap_a: assert property (rel |-> gap_q >= MIN_GAP)
    else $error("release before timer end");
  fault_freeze_a: assert property (fault_held |-> $stable(o_stop_pwr) && $stable(o_body_pwr))
    else $error("power changed while halted");
  led_excl_a: assert property ((o_led_red & o_led_green) == 32'h0)
    else $error("red and green both lit");
endmodule

bind staging_yard_sequencer yard_seq_checker #(
  .SEC_CYCLES(SEC_CYCLES), .PULSE_CYCLES(PULSE_CYCLES), .DB_CYCLES(DB_CYCLES)
) yard_seq_checker_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_inhibit_n(i_inhibit_n), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_stop_pwr(o_stop_pwr), .o_body_pwr(o_body_pwr),
  .o_turn_branch(o_turn_branch), .o_turn_through(o_turn_through),
  .o_led_red(o_led_red), .o_led_green(o_led_green), .o_fault(o_fault)
);

// ==== sim/yard_track_model.sv ====
// trains on the sidings: arrive on command, leave once both sections are powered
`timescale 1ns/1ps
module yard_track_model #(
  parameter logic [31:0] INIT_OCC      = 32'h1,
  parameter int unsigned DEPART_CYCLES = 10
) (
  input  wire logic        i_clock,    // clock
  input  wire logic [31:0] i_stop_pwr, // section a power
  input  wire logic [31:0] i_body_pwr, // section b power
  input  wire logic [31:0] i_arrive,   // train enters siding
  input  wire logic [31:0] i_stuck,    // car left behind
  output logic      [31:0] o_occ       // detector outputs
);
  logic [31:0] occ_q = INIT_OCC;
  int unsigned run_q [32];
  assign o_occ = occ_q;
  // a stuck car keeps the detector lit however long the siding is powered
  always @(posedge i_clock) begin
    for (int k = 0; k < 32; k++) begin
      if (i_arrive[k])
        occ_q[k] <= 1'b1;
      if (i_stop_pwr[k] && i_body_pwr[k] && !i_stuck[k]) begin
        run_q[k] <= run_q[k] + 1;
        if (run_q[k] == DEPART_CYCLES)
          occ_q[k] <= 1'b0;
      end else
        run_q[k] <= 0;
    end
  end
endmodule

// ==== sim/staging_yard_sequencer_tb.sv ====
// self-checking bench for the staging yard sequencer
`timescale 1ns/1ps
`include "yard_map.svh"
module staging_yard_sequencer_tb;
  logic        i_clock = 1'b0;
  logic        i_rst   = 1'b1;
  logic [31:0] occ, stop, body, red, green, rdata;
  logic [31:0] btn = '0, xbtn = '0, arr = '0, stuck = '0, wdata = '0, om;
  logic        inh_n = 1'b1, volt = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rd_pend = 1'b0;
  logic [7:0]  addr = '0;
  logic [1:0]  fault;
  logic [2:0]  mode_led;
  logic [63:0] ent;
  logic [63:0] exp_q [$];
  logic [31:0] tb, tt, tbs = '0, tts = '0;
  logic [15:0] fled;
  logic [14:0] units = 15'h0003;
  logic        strap = 1'b1, entry, nv_we;
  logic [2:0]  mbtn = '0;
  logic [1:0]  nv = 2'h1, mode_nv;
  int          nvw = 0;
  logic [4:0]  dv [4] = '{5'h15, 5'h01, 5'h14, 5'h02};
  logic [4:0]  de [4] = '{5'h05, 5'h05, 5'h14, 5'h02};
  int          fails = 0, tests_run = 0, k;
  int          seed = 32'h6952;
  int          pick [3] = '{1, 2, 4};

  always #5 i_clock = ~i_clock;

  staging_yard_sequencer #(.SEC_CYCLES(20), .PULSE_CYCLES(5), .DB_CYCLES(2))
    staging_yard_sequencer_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_occ(occ), .i_exit_btn(btn),
    .i_exit_btn_ext(xbtn), .i_unit_present(units), .i_single_strap(strap),
    .i_inhibit_n(inh_n), .i_track_volt_ok(volt), .i_mode_btn(mbtn), .i_mode_nv(nv),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_stop_pwr(stop), .o_body_pwr(body), .o_turn_branch(tb), .o_turn_through(tt),
    .o_led_red(red), .o_led_green(green), .o_entry_pwr(entry), .o_fault(fault),
    .o_fault_led(fled), .o_mode_led(mode_led), .o_mode_nv_we(nv_we), .o_mode_nv(mode_nv));

  yard_track_model #(.INIT_OCC(32'h1), .DEPART_CYCLES(10)) yard_track_model_i (
    .i_clock(i_clock), .i_stop_pwr(stop), .i_body_pwr(body), .i_arrive(arr),
    .i_stuck(stuck), .o_occ(occ));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    cyc(1);
    wr_s  <= 1'b0;
    cyc(1);
  endtask
  // expected word is queued with a mask, the watcher compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd_s <= 1'b1;
    exp_q.push_back({m, e});
    cyc(1);
    rd_s <= 1'b0;
    cyc(1);
  endtask
  task automatic press(input int s, input bit ext);
    if (ext)
      xbtn[s] <= 1'b1;
    else
      btn[s] <= 1'b1;
    cyc(12);
    btn  <= '0;
    xbtn <= '0;
    cyc(1);
  endtask
  task automatic arrive(input int s);
    arr[s] <= 1'b1;
    cyc(1);
    arr <= '0;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge i_clock) begin
    if (rd_pend) begin
      ent = exp_q.pop_front();
      chk(rdata & ent[63:32], ent[31:0]);
    end
    rd_pend <= rd_s;
    // outputs are unknown until the first reset edge has passed
    if (!i_rst) begin
      tbs <= tbs | tb;
      tts <= tts | tt;
      if (nv_we === 1'b1)
        nvw <= nvw + 1;
    end
  end

  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    print_verdict();
  end

  initial begin
    cyc(6);
    i_rst <= 1'b0;
    cyc(60);
    chk(32'(mode_led), 32'h2);
    chk(stop, 32'h0);
    chk(body, 32'h1e);
    chk(red, 32'h1);
    chk(tbs, 32'h1e);
    chk(tts, 32'h1);
    chk(32'(entry), 32'h1);
    rd(`YARD_ADR_DEPART, 32'h1f, 32'h5);
    rd(`YARD_ADR_STATUS, 32'h3f, 32'h5);
    done("startup");
    for (int j = 0; j < 4; j++) begin
      wr(`YARD_ADR_DEPART, {27'h0, dv[j]});
      rd(`YARD_ADR_DEPART, 32'h1f, {27'h0, de[j]});
    end
    wr(8'h40, $random(seed));
    rd(8'h40, 32'hffffffff, 32'h0);
    k = nvw;
    for (int m = 0; m < 3; m++) begin
      wr(`YARD_ADR_CTRL, 32'(m));
      cyc(2);
      chk(32'(mode_led), 32'h1 << m);
      chk(32'(mode_nv), 32'(m));
      rd(`YARD_ADR_CTRL, 32'h3, 32'(m));
    end
    chk(32'(nvw - k), 32'h3);
    done("registers");
    arrive(2);
    cyc(20);
    chk(body, 32'h1b);
    chk(stop, 32'h1);
    chk(tts, 32'h5);
    cyc(60);
    chk(stop, 32'h0);
    chk(tbs, 32'h1f);
    arrive(1);
    cyc(20);
    chk(stop, 32'h4);
    cyc(60);
    done("fifo");
    wr(`YARD_ADR_CTRL, 32'h0);
    inh_n <= 1'b0;
    cyc(12);
    press(1, 1'b0);
    cyc(10);
    chk(stop, 32'h0);
    inh_n <= 1'b1;
    cyc(12);
    press(1, 1'b1);
    cyc(10);
    chk(stop, 32'h2);
    arrive(3);
    cyc(4);
    press(3, 1'b0);
    cyc(4);
    chk(stop, 32'h2);
    chk(body, 32'h17);
    cyc(60);
    done("manual");
    stuck[3] <= 1'b1;
    press(3, 1'b0);
    cyc(60);
    chk(32'(fault), 32'h2);
    rd(`YARD_ADR_STATUS, 32'h180000, 32'h100000);
    press(3, 1'b1);
    chk(32'(fault), 32'h2);
    wr(`YARD_ADR_CTRL, 32'h8);
    cyc(40);
    chk(32'(fault), 32'h0);
    chk(body, 32'h17);
    done("car left");
    volt <= 1'b0;
    cyc(20);
    chk(32'(fault), 32'h1);
    chk(32'(fled), 32'h7);
    volt <= 1'b1;
    cyc(20);
    chk(32'(fault), 32'h0);
    done("voltage");
    units <= 15'h0001;
    cyc(20);
    chk(32'(fault), 32'h3);
    chk(32'(fled), 32'h4);
    units <= 15'h0003;
    strap <= 1'b0;
    cyc(12);
    wr(`YARD_ADR_CTRL, 32'h8);
    cyc(10);
    rd(`YARD_ADR_STATUS, 32'h3f, 32'h6);
    chk(32'(fault), 32'h0);
    mbtn <= 3'h2;
    cyc(12);
    mbtn <= 3'h0;
    cyc(2);
    chk(32'(mode_led), 32'h2);
    chk(32'(mode_nv), 32'h1);
    done("units");
    wr(`YARD_ADR_CTRL, 32'h1);
    k = pick[$unsigned($random(seed)) % 3];
    om = 32'h8 | (32'h1 << k);
    arrive(k);
    cyc(20);
    chk(32'($onehot(stop & om)), 32'h1);
    chk(stop & ~om, 32'h0);
    done("random");
    print_verdict();
  end
endmodule
